/* core/pi_interrupt_wait.sv */
// Priority interrupt logic and ready/wait transfer handshake of the processor board.
// Assumes the instruction decoder supplies one-cycle event strobes on this clock, and that
// request flags, ready and read data arrive from pins outside this clock's domain.
//
// What this block does
// - Without ready before transfer, insert wait cycles; accept data in following transfer state.
// - Eight levels; level 0 ignores both the global mask and enable bits.
// - Levels 1 to 7 gated by global mask and enable bits from port 23.
// - Acknowledge a level at the moment its request is recognised.
// - Among eligible requests the highest-numbered level is recognised first.
// - Priority counts only at recognition; a routine's first instruction is uninterruptible.
// - Disabled or masked requests stay pending until enabled and unmasked.
// - The instruction in progress completes fully before program flow is diverted.
// - Branch to page-zero address eight times the level number.
// - Mask-all sets the global mask; unmask clears it for immediate interrupts.
// - Port 23 write loads enables: bit 0 watchdog, bits 1 to 7 levels.
// - Return-with-unmask returns and clears the mask in one indivisible step.
// - Strapped clock drives level 7; its acknowledge clears the clock request internally.
// - Standard real-time clock period is one pulse every 10 milliseconds.
// - The clock interval restarts whenever level 7 becomes both enabled and unmasked.
`timescale 1ns/100ps
`default_nettype none

module pi_interrupt_wait #(
   parameter int RTC_PERIOD_CYC = pi_pkg::RTC_PERIOD_CYC
) (
   // Clock and reset
   input  wire logic                          clock,
   input  wire logic                          rst,
   // Instruction decoder events
   input  wire logic                          instr_end,
   input  wire logic                          mask_all_instr,
   input  wire logic                          unmask_all_instr,
   input  wire logic                          return_unmask_instr,
   input  wire logic                          io_wr,
   input  wire logic [4:0]                    io_port,
   input  wire logic [7:0]                    io_data,
   // Backplane transfer
   input  wire logic                          cycle_start,
   input  wire logic                          ready_n,
   input  wire logic [7:0]                    bus_data,
   // Interrupt request pins and strap
   input  wire logic [pi_pkg::NUM_LEVELS-1:0] irq_req,
   input  wire logic                          rtc_strap,
   // Interrupt outputs
   output var  logic [pi_pkg::NUM_LEVELS-1:0] irq_ack_q,
   output var  logic                          vector_valid_q,
   output var  logic [pi_pkg::ADDR_W-1:0]     vector_addr_q,
   output var  logic                          global_mask_q,
   output var  logic [pi_pkg::NUM_LEVELS-1:0] enable_mask_q,
   output var  logic                          watchdog_q,
   output var  logic                          rtc_pulse,
   // Transfer outputs
   output var  logic                          wait_q,
   output var  logic                          xfer_q,
   output var  logic                          data_accept_q,
   output var  logic [7:0]                    read_data_q,
   // Board clear
   output var  logic                          processor_clear_out
);

   localparam int NL     = pi_pkg::NUM_LEVELS;
   localparam int SYNC_W = NL + 1 + 8;
   localparam int RDY_W  = $clog2(pi_pkg::READY_DEADLINE_CYC + 1);
   localparam int HO_W   = $clog2(pi_pkg::ACK_HOLDOFF_CYC + 1);
   localparam logic [RDY_W-1:0] RDY_LAST = RDY_W'(pi_pkg::READY_DEADLINE_CYC - 1);
   localparam logic [HO_W-1:0]  HO_LOAD  = HO_W'(pi_pkg::ACK_HOLDOFF_CYC);

   // ==========================================================================
   // Pin synchronisers
   // ==========================================================================
   // Stage one feeds only stage two; a change is taken once stages two and three agree.
   logic [SYNC_W-1:0] pin_raw;
   logic [SYNC_W-1:0] s1_q;
   logic [SYNC_W-1:0] s2_q;
   logic [SYNC_W-1:0] s3_q;
   logic [SYNC_W-1:0] stable_q;
   logic [SYNC_W-1:0] stable_d;

   assign pin_raw = {bus_data, ready_n, irq_req};

   always_comb begin
      for (int i = 0; i < SYNC_W; i++) begin
         stable_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stable_q[i];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s1_q     <= '0;
         s2_q     <= '0;
         s3_q     <= '0;
         stable_q <= '0;
      end else begin
         s1_q     <= pin_raw;
         s2_q     <= s1_q;
         s3_q     <= s2_q;
         stable_q <= stable_d;
      end
   end

   logic [NL-1:0] req_sync;
   logic          ready_low;
   logic [7:0]    data_sync;

   assign req_sync  = stable_q[NL-1:0];
   assign ready_low = ~stable_q[NL];
   assign data_sync = stable_q[SYNC_W-1:NL+1];

   // ==========================================================================
   // Strap capture and board clear
   // ==========================================================================
   // The strap is taken once, on the first edge after reset release, and then frozen.
   logic strap_seen_q;
   logic strap_q;
   logic strap_d;
   logic clear_q;

   always_comb begin
      strap_d = strap_seen_q ? strap_q : rtc_strap;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         strap_seen_q <= 1'b0;
         strap_q      <= 1'b0;
         clear_q      <= 1'b1;
      end else begin
         strap_seen_q <= 1'b1;
         strap_q      <= strap_d;
         clear_q      <= 1'b0;
      end
   end

   assign processor_clear_out = clear_q;

   // ==========================================================================
   // Global mask and enable mask
   // ==========================================================================
   logic          mask_d;
   logic [NL-1:0] enable_d;
   logic          open7_q;
   logic          open7_d;
   logic          rtc_restart;

   always_comb begin
      mask_d   = global_mask_q;
      enable_d = enable_mask_q;
      if (mask_all_instr) begin
         mask_d = 1'b1;
      end else if (unmask_all_instr || return_unmask_instr) begin
         // The return path clears the mask in the same cycle it pops, leaving no gap.
         mask_d = 1'b0;
      end
      if (io_wr && (io_port == pi_pkg::ENABLE_PORT)) begin
         enable_d = io_data;
      end
      open7_d = enable_d[pi_pkg::RTC_LEVEL] & ~mask_d;
   end

   assign rtc_restart = open7_d & ~open7_q;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         global_mask_q <= pi_pkg::MASK_RESET;
         enable_mask_q <= pi_pkg::ENABLE_RESET;
         open7_q       <= 1'b0;
      end else begin
         global_mask_q <= mask_d;
         enable_mask_q <= enable_d;
         open7_q       <= open7_d;
      end
   end

   assign watchdog_q = enable_mask_q[pi_pkg::WDOG_BIT];

   // ==========================================================================
   // Real-time clock request
   // ==========================================================================
   logic rtc_tick;
   logic rtc_flag_q;
   logic rtc_flag_d;

   pi_rtc_timer #(
      .PERIOD_CYC (RTC_PERIOD_CYC)
   ) u_rtc (
      .clock   (clock),
      .rst     (rst),
      .restart (rtc_restart),
      .tick    (rtc_tick)
   );

   assign rtc_pulse = rtc_tick;

   // A tick arriving with the acknowledge survives, so no clock period is lost.
   always_comb begin
      rtc_flag_d = rtc_flag_q;
      if (irq_ack_q[pi_pkg::RTC_LEVEL]) begin
         rtc_flag_d = 1'b0;
      end
      if (rtc_tick) begin
         rtc_flag_d = 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rtc_flag_q <= 1'b0;
      end else begin
         rtc_flag_q <= rtc_flag_d;
      end
   end

   // ==========================================================================
   // Recognition, acknowledge and vectoring
   // ==========================================================================
   logic [NL-1:0]           req_eff;
   logic [NL-1:0]           eligible;
   logic [pi_pkg::LEVEL_W-1:0] pick;
   logic                    any_elig;
   pi_pkg::pi_irq_e         irq_q;
   pi_pkg::pi_irq_e         irq_d;
   logic [pi_pkg::LEVEL_W-1:0] level_q;
   logic [pi_pkg::LEVEL_W-1:0] level_d;
   logic [HO_W-1:0]         hold_q;
   logic [HO_W-1:0]         hold_d;
   logic [NL-1:0]           ack_d;
   logic                    vec_valid_d;
   logic [pi_pkg::ADDR_W-1:0] vec_addr_d;

   always_comb begin
      req_eff = req_sync;
      if (strap_q) begin
         req_eff[pi_pkg::RTC_LEVEL] = rtc_flag_q;
      end
      // Level 0 bypasses both gates; the others need enable and no global mask.
      eligible = req_eff & enable_mask_q & {NL{~global_mask_q}};
      eligible[pi_pkg::INIT_LEVEL] = req_eff[pi_pkg::INIT_LEVEL];
      any_elig = |eligible;
      pick = '0;
      for (int i = 0; i < NL; i++) begin
         if (eligible[i]) begin
            pick = pi_pkg::LEVEL_W'(i);
         end
      end
   end

   // The synchronised request lags the cleared flag, so a short holdoff stops a stale retake.
   always_comb begin
      irq_d       = irq_q;
      level_d     = level_q;
      hold_d      = (hold_q != '0) ? hold_q - HO_W'(1) : hold_q;
      ack_d       = '0;
      vec_valid_d = 1'b0;
      vec_addr_d  = vector_addr_q;
      case (irq_q)
         pi_pkg::PI_IRQ_IDLE: begin
            if (any_elig && (hold_q == '0)) begin
               level_d      = pick;
               ack_d[pick]  = 1'b1;
               hold_d       = HO_LOAD;
               irq_d        = pi_pkg::PI_IRQ_HELD;
               if (instr_end) begin
                  vec_valid_d = 1'b1;
                  vec_addr_d  = {pi_pkg::VEC_PAGE, pi_pkg::VEC_MID_ZERO, pick, pi_pkg::VEC_LOW_ZERO};
                  irq_d       = pi_pkg::PI_IRQ_FIRST;
               end
            end
         end
         pi_pkg::PI_IRQ_HELD: begin
            if (instr_end) begin
               vec_valid_d = 1'b1;
               vec_addr_d  = {pi_pkg::VEC_PAGE, pi_pkg::VEC_MID_ZERO, level_q, pi_pkg::VEC_LOW_ZERO};
               irq_d       = pi_pkg::PI_IRQ_FIRST;
            end
         end
         pi_pkg::PI_IRQ_FIRST: begin
            if (instr_end) begin
               irq_d = pi_pkg::PI_IRQ_IDLE;
            end
         end
         default: begin
            irq_d = pi_pkg::PI_IRQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq_q          <= pi_pkg::PI_IRQ_IDLE;
         level_q        <= '0;
         hold_q         <= '0;
         irq_ack_q      <= '0;
         vector_valid_q <= 1'b0;
         vector_addr_q  <= '0;
      end else begin
         irq_q          <= irq_d;
         level_q        <= level_d;
         hold_q         <= hold_d;
         irq_ack_q      <= ack_d;
         vector_valid_q <= vec_valid_d;
         vector_addr_q  <= vec_addr_d;
      end
   end

   // ==========================================================================
   // Ready and wait handshake
   // ==========================================================================
   // Ready is judged when the deadline after the upper address runs out; later ready costs waits.
   pi_pkg::pi_bus_e bus_q;
   pi_pkg::pi_bus_e bus_d;
   logic [RDY_W-1:0] rdy_cnt_q;
   logic [RDY_W-1:0] rdy_cnt_d;
   logic             wait_d;
   logic             xfer_d;
   logic             accept_d;
   logic [7:0]       rdata_d;

   always_comb begin
      bus_d     = bus_q;
      rdy_cnt_d = rdy_cnt_q;
      wait_d    = 1'b0;
      xfer_d    = 1'b0;
      accept_d  = 1'b0;
      rdata_d   = read_data_q;
      case (bus_q)
         pi_pkg::PI_BUS_IDLE: begin
            if (cycle_start) begin
               rdy_cnt_d = '0;
               bus_d     = pi_pkg::PI_BUS_ADDR;
            end
         end
         pi_pkg::PI_BUS_ADDR: begin
            rdy_cnt_d = rdy_cnt_q + RDY_W'(1);
            if (rdy_cnt_q == RDY_LAST) begin
               if (ready_low) begin
                  bus_d  = pi_pkg::PI_BUS_XFER;
                  xfer_d = 1'b1;
               end else begin
                  bus_d  = pi_pkg::PI_BUS_WAIT;
                  wait_d = 1'b1;
               end
            end
         end
         pi_pkg::PI_BUS_WAIT: begin
            if (ready_low) begin
               bus_d  = pi_pkg::PI_BUS_XFER;
               xfer_d = 1'b1;
            end else begin
               wait_d = 1'b1;
            end
         end
         pi_pkg::PI_BUS_XFER: begin
            // The card holds data through this state, so one sample of the settled copy is enough.
            rdata_d  = data_sync;
            accept_d = 1'b1;
            bus_d    = pi_pkg::PI_BUS_IDLE;
         end
         default: begin
            bus_d = pi_pkg::PI_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bus_q         <= pi_pkg::PI_BUS_IDLE;
         rdy_cnt_q     <= '0;
         wait_q        <= 1'b0;
         xfer_q        <= 1'b0;
         data_accept_q <= 1'b0;
         read_data_q   <= '0;
      end else begin
         bus_q         <= bus_d;
         rdy_cnt_q     <= rdy_cnt_d;
         wait_q        <= wait_d;
         xfer_q        <= xfer_d;
         data_accept_q <= accept_d;
         read_data_q   <= rdata_d;
      end
   end

endmodule

`default_nettype wire

/* core/pi_pkg.sv */
// Constants, encodings and timing figures for the processor interrupt and wait logic.
// Assumes a single 125 MHz machine-state clock shared by every file that imports nothing and names pi_pkg::.
package pi_pkg;

   // ==========================================================================
   // Interrupt levels and the enable-mask port
   // ==========================================================================
   localparam int          NUM_LEVELS   = 8;
   localparam int          LEVEL_W      = 3;
   localparam int          RTC_LEVEL    = 7;
   localparam int          INIT_LEVEL   = 0;
   localparam logic [4:0]  ENABLE_PORT  = 5'h17;
   localparam int          WDOG_BIT     = 0;
   localparam logic [7:0]  ENABLE_RESET = 8'h00;
   localparam logic        MASK_RESET   = 1'b1;

   // ==========================================================================
   // Page-zero vector layout
   // ==========================================================================
   localparam int          ADDR_W       = 14;
   localparam logic [5:0]  VEC_PAGE     = 6'h00;
   localparam logic [2:0]  VEC_LOW_ZERO = 3'h0;
   localparam logic [1:0]  VEC_MID_ZERO = 2'h0;

   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int          CLK_PERIOD_NS      = 8;
   localparam int          RTC_PERIOD_MS      = 10;
   localparam int          RTC_PERIOD_CYC     = (RTC_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
   localparam int          READY_DEADLINE_NS  = 500;
   localparam int          READY_DEADLINE_CYC = (READY_DEADLINE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                                (READY_DEADLINE_NS / CLK_PERIOD_NS);
   localparam int          ACK_HOLDOFF_CYC    = 6;

   // ==========================================================================
   // State encodings
   // ==========================================================================
   typedef enum logic [1:0] {
      PI_BUS_IDLE = 2'b00,
      PI_BUS_ADDR = 2'b01,
      PI_BUS_XFER = 2'b11,
      PI_BUS_WAIT = 2'b10
   } pi_bus_e;

   typedef enum logic [1:0] {
      PI_IRQ_IDLE  = 2'b00,
      PI_IRQ_HELD  = 2'b01,
      PI_IRQ_FIRST = 2'b11
   } pi_irq_e;

endpackage

/* core/pi_rtc_timer.sv */
// Retriggerable real-time clock interval timer.
// Assumes restart is a one-cycle pulse on the same clock; tick is a one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none

module pi_rtc_timer #(
   parameter int PERIOD_CYC = pi_pkg::RTC_PERIOD_CYC
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // Control
   input  wire logic restart,
   // Pulse out
   output var  logic tick
);

   localparam int CNT_W = $clog2(PERIOD_CYC + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD_CYC - 1);

   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;
   logic             tick_q;
   logic             tick_d;

   // ==========================================================================
   // Interval counter
   // ==========================================================================
   // A restart reloads the count so the next tick lands a full period later.
   always_comb begin
      count_d = count_q + CNT_W'(1);
      tick_d  = 1'b0;
      if (restart) begin
         count_d = '0;
      end else if (count_q == LAST) begin
         count_d = '0;
         tick_d  = 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count_q <= '0;
         tick_q  <= 1'b0;
      end else begin
         count_q <= count_d;
         tick_q  <= tick_d;
      end
   end

   assign tick = tick_q;

endmodule

`default_nettype wire

/* tb/pi_interrupt_wait_assertions.sv */
// Concurrent checks on the ports of the interrupt and wait logic.
// Assumes one clock domain and reset active high.
`timescale 1ns/100ps
`default_nettype none

module pi_interrupt_wait_assertions #(
   parameter int RTC_PERIOD_CYC = 50
) (
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst,
   // Decoder events
   input wire logic        instr_end,
   input wire logic        mask_all_instr,
   input wire logic        unmask_all_instr,
   input wire logic        return_unmask_instr,
   input wire logic        io_wr,
   input wire logic [4:0]  io_port,
   input wire logic [7:0]  io_data,
   // Interrupt outputs
   input wire logic [7:0]  irq_ack_q,
   input wire logic        vector_valid_q,
   input wire logic [13:0] vector_addr_q,
   input wire logic        global_mask_q,
   input wire logic [7:0]  enable_mask_q,
   input wire logic        rtc_pulse,
   // Transfer outputs
   input wire logic        wait_q,
   input wire logic        xfer_q,
   input wire logic        data_accept_q
);
   // ==========================================================================
   // Helper logic
   // ==========================================================================
   int rtc_cnt_q;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // A restart only lengthens an interval, so a gap shorter than the period is always a fault.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) rtc_cnt_q <= 0;
      else if (rtc_pulse) rtc_cnt_q <= 0;
      else rtc_cnt_q <= rtc_cnt_q + 1;
   end

   sequence s_wait_end;
      wait_q ##1 !wait_q;
   endsequence

   sequence s_xfer_done;
      xfer_q ##1 data_accept_q;
   endsequence

   // ==========================================================================
   // Assertions
   // ==========================================================================
   a_wait_then_xfer: assert property (s_wait_end |-> ##[0:1] xfer_q)
      else $error("wait ended without a transfer");
   a_wait_no_xfer: assert property (wait_q |-> !xfer_q)
      else $error("transfer during a wait cycle");
   a_xfer_accept: assert property (xfer_q |-> s_xfer_done)
      else $error("transfer not followed by accept");
   a_enable_load: assert property (io_wr && io_port == pi_pkg::ENABLE_PORT |=> enable_mask_q == $past(io_data))
      else $error("enable mask not loaded");
   a_port_ignored: assert property (io_wr && io_port != pi_pkg::ENABLE_PORT |=> $stable(enable_mask_q))
      else $error("enable mask changed by another port");
   a_mask_set: assert property (mask_all_instr |=> global_mask_q)
      else $error("mask not set");
   a_mask_clear: assert property ((unmask_all_instr || return_unmask_instr) && !mask_all_instr |=> !global_mask_q)
      else $error("mask not cleared");
   a_ack_gated: assert property (|irq_ack_q[7:1] |-> !$past(global_mask_q) &&
      (irq_ack_q[7:1] & ~$past(enable_mask_q[7:1])) == 7'h00)
      else $error("acknowledge on a gated level");
   a_ack_single: assert property (|irq_ack_q |-> $onehot(irq_ack_q) ##1 irq_ack_q == 8'h00)
      else $error("acknowledge not a single one-cycle pulse");
   a_vec_at_end: assert property (vector_valid_q |-> $past(instr_end) && vector_addr_q[13:6] == 8'h00 &&
      vector_addr_q[2:0] == 3'h0)
      else $error("branch not at instruction end or off page zero");
   a_rtc_period: assert property (rtc_pulse |-> rtc_cnt_q >= RTC_PERIOD_CYC - 1)
      else $error("clock pulse too early");
endmodule
`default_nettype wire

/* tb/pi_card_model.sv */
// Request flags and one addressed interface card on the backplane.
// Assumes the bench pulses set_req and sets the card's ready delay and data before each transfer.
`timescale 1ns/100ps
`default_nettype none

module pi_card_model (
   // Clock and reset
   input wire logic  clock,
   input wire logic  rst,
   // Bench controls
   input wire logic [7:0] set_req,
   input wire logic [7:0] dly,
   input wire logic [7:0] data,
   // Processor side
   input wire logic [7:0] irq_ack_q,
   input wire logic  cycle_start,
   input wire logic  data_accept_q,
   output logic [7:0] irq_req,
   output logic       ready_n,
   output logic [7:0] bus_data
);
   logic       busy_q;
   logic [7:0] cnt_q;

   // Released lines float to the pull-up level, never to the last value driven.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq_req <= 8'h00;
         busy_q <= 1'b0;
         cnt_q <= 8'h00;
         ready_n <= 1'b1;
         bus_data <= 8'hff;
      end else begin
         irq_req <= (irq_req | set_req) & ~irq_ack_q;
         if (cycle_start) begin
            busy_q <= 1'b1;
            cnt_q <= 8'h00;
         end else if (data_accept_q) begin
            busy_q <= 1'b0;
            ready_n <= 1'b1;
            bus_data <= 8'hff;
         end else if (busy_q) begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q >= dly) begin
               ready_n <= 1'b0;
               bus_data <= data;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* tb/pi_interrupt_wait_bench.sv */
// Self-checking bench for the interrupt and wait logic.
// Assumes the package, design, card model and checker are compiled before this file.
`timescale 1ns/100ps
`default_nettype none

module pi_interrupt_wait_bench;
   localparam int RTC_P = 50;
   logic        clock = 1'b0, rst = 1'b1, instr_end = 1'b0, cycle_start = 1'b0;
   logic        mask_all_instr = 1'b0, unmask_all_instr = 1'b0, return_unmask_instr = 1'b0;
   logic        io_wr = 1'b0, strap = 1'b0, clr;
   logic [4:0]  io_port = 5'h00;
   logic [7:0]  io_data = 8'h00, set_req = 8'h00, dly = 8'h00, data = 8'h00;
   logic        ready_n, vector_valid_q, global_mask_q, watchdog_q, rtc_pulse, wait_q, data_accept_q;
   logic [7:0]  bus_data, irq_req, irq_ack_q, enable_mask_q, read_data_q;
   logic [13:0] vector_addr_q;
   int          num_errors = 0, n_tests = 0, cyc = 0, n;

   pi_interrupt_wait #(.RTC_PERIOD_CYC(RTC_P)) dut_u (.clock, .rst, .instr_end, .mask_all_instr,
      .unmask_all_instr, .return_unmask_instr, .io_wr, .io_port, .io_data, .cycle_start, .ready_n,
      .bus_data, .irq_req, .rtc_strap(strap), .irq_ack_q, .vector_valid_q, .vector_addr_q, .global_mask_q,
      .enable_mask_q, .watchdog_q, .rtc_pulse, .wait_q, .xfer_q(), .data_accept_q, .read_data_q,
      .processor_clear_out(clr));

   pi_card_model card_u (.clock, .rst, .set_req, .dly, .data, .irq_ack_q, .cycle_start, .data_accept_q,
      .irq_req, .ready_n, .bus_data);

   // ==========================================================================
   // Clock, instruction pacing and hang guard
   // ==========================================================================
   always #4 clock = ~clock;

   always @(posedge clock) begin
      cyc++;
      instr_end <= (cyc % 4 == 0);
      if (cyc > 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   // ==========================================================================
   // Tasks
   // ==========================================================================
   task t(input int k);
      repeat (k) @(posedge clock);
   endtask

   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task ev(input logic [2:0] k);
      t(1);
      {mask_all_instr, unmask_all_instr, return_unmask_instr} <= k;
      t(1);
      {mask_all_instr, unmask_all_instr, return_unmask_instr} <= 3'h0;
   endtask

   task io_write(input logic [4:0] p, input logic [7:0] d);
      t(1);
      io_wr <= 1'b1;
      io_port <= p;
      io_data <= d;
      t(1);
      io_wr <= 1'b0;
   endtask

   task req(input logic [7:0] b);
      t(1);
      set_req <= b;
      t(1);
      set_req <= 8'h00;
   endtask

   // Waits for the acknowledge, then the branch, and returns at once so a pending level is not missed.
   task grab(input logic [2:0] l);
      n = 0;
      while (irq_ack_q === 8'h00 && n < 80) begin t(1); #1; n++; end
      check(16'(irq_ack_q), 16'(8'h01 << l));
      while (vector_valid_q !== 1'b1 && n < 80) begin t(1); #1; n++; end
      check(16'(vector_addr_q), 16'({l, 3'h0}));
   endtask

   task xfer(input logic [7:0] dl, input logic [7:0] d, input logic w);
      logic sw;
      sw = 1'b0;
      n = 0;
      t(1);
      dly <= dl;
      data <= d;
      cycle_start <= 1'b1;
      t(1);
      cycle_start <= 1'b0;
      while (data_accept_q !== 1'b1 && n < 300) begin t(1); #1; sw = sw | wait_q; n++; end
      check(16'(read_data_q), 16'(d));
      check(16'(sw), 16'(w));
   endtask

   task tally_and_finish();
      if (num_errors == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // ==========================================================================
   // Test sequence
   // ==========================================================================
   initial begin
      t(16);
      rst <= 1'b0;
      t(4);
      #1;
      check(16'(global_mask_q), 16'h1);
      req(8'h01);
      grab(3'h0);
      io_write(5'h16, 8'hff);
      io_write(5'h17, 8'h82);
      #1;
      check(16'(enable_mask_q), 16'h82);
      check(16'(watchdog_q), 16'h0);
      req(8'h08);
      ev(3'b010);
      t(20);
      check(16'(irq_req), 16'h8);
      io_write(5'h17, 8'hff);
      grab(3'h3);
      ev(3'b100);
      req(8'h24);
      t(20);
      check(16'(irq_req), 16'h24);
      ev(3'b010);
      grab(3'h5);
      grab(3'h2);
      ev(3'b100);
      req(8'h10);
      t(20);
      ev(3'b001);
      grab(3'h4);
      for (int i = 1; i < 8; i++) begin
         req(8'h01 << i);
         grab(3'(i));
      end
      xfer(8'd10, 8'h5a, 1'b0);
      xfer(8'd100, 8'ha5, 1'b1);
      ev(3'b100);
      ev(3'b010);
      n = 0;
      do begin t(1); #1; n++; end while (rtc_pulse !== 1'b1 && n < 200);
      check(16'(n), 16'(RTC_P));
      n = 0;
      do begin t(1); #1; n++; end while (rtc_pulse !== 1'b1 && n < 200);
      check(16'(n), 16'(RTC_P));
      t(1);
      strap <= 1'b1;
      rst <= 1'b1;
      t(2);
      check(16'(clr), 16'h1);
      rst <= 1'b0;
      io_write(5'h17, 8'h80);
      check(16'(clr), 16'h0);
      ev(3'b010);
      grab(3'h7);
      n = 0;
      do begin t(1); #1; n++; end while (irq_ack_q === 8'h00 && n < 40);
      check(16'(n), 16'h28);
      tally_and_finish();
   end
endmodule

bind pi_interrupt_wait pi_interrupt_wait_assertions #(.RTC_PERIOD_CYC(RTC_PERIOD_CYC)) chk_u (.clock, .rst,
   .instr_end, .mask_all_instr, .unmask_all_instr, .return_unmask_instr, .io_wr, .io_port, .io_data,
   .irq_ack_q, .vector_valid_q, .vector_addr_q, .global_mask_q, .enable_mask_q, .rtc_pulse, .wait_q,
   .xfer_q, .data_accept_q);
`default_nettype wire
